// File: dpc_pkg.sv
// Constants and types for the DDR2 CKE power-state controller
package dpc_pkg;
	// Command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_DESEL = 4'h8;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_LM = 4'h0;
	// Request codes on the user port
	localparam logic [1:0] REQ_PDN = 2'h1;
	localparam logic [1:0] REQ_SREF = 2'h2;
	localparam logic [1:0] REQ_FCHG = 2'h3;
	// Timing in clocks of the memory clock, except the _NS values in ns
	localparam int CKE_MIN_CK = 3;
	localparam int FCHG_WAIT_CK = 2;
	localparam int SR_READ_CK = 200;
	localparam int DLL_RELOCK_CK = 200;
	localparam int XSNR_NS = 200;
	localparam int CLK_PERIOD_NS = 20;
	localparam int XSNR_CK = (XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [7:0] CKE_HOLD = 8'(CKE_MIN_CK - 1);
	localparam logic [7:0] FCHG_HOLD = 8'(FCHG_WAIT_CK);
	localparam logic [7:0] READ_HOLD = 8'(SR_READ_CK);
	localparam logic [7:0] NR_HOLD = 8'(XSNR_CK);
	localparam logic [7:0] RELOCK_HOLD = 8'(DLL_RELOCK_CK);
	// Mode register DLL reset bit (A8)
	localparam int MR_DLL_RST_BIT = 8;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_ENTER = 3'b001,
		ST_PDN = 3'b010,
		ST_SREF = 3'b011,
		ST_FCHG = 3'b100,
		ST_EXIT = 3'b101,
		ST_RELOCK = 3'b110
	} dpc_state_e;
endpackage

// File: dpc_ctrl.sv
// Host-side CKE power-state controller for a DDR2 SDRAM
//
// What this block does
// - Self refresh entered by CKE falling with REFRESH, only when all idle.
// - Only NOP or DESELECT on power-down entry and exit edges.
// - Self refresh exit by raising CKE with NOP or DESELECT.
// - After self refresh exit, NOPs for exit interval; no READ before 200 clocks.
// - ODT driven to a defined level during power-down when enabled.
// - Never produce a CKE, state and command combination not listed valid.
// - No low-power entry while read, write, load or precharge runs.
// - CKE held at least three clocks after each transition.
// - Entry after a read only once its burst has completed.
// - Entry after a write only once its burst has completed.
// - After write with auto precharge, entry one clock after write recovery.
// - Precharge power-down may follow REFRESH by one clock.
// - Active power-down may follow ACTIVATE by one clock.
// - Precharge power-down may follow PRECHARGE by one clock.
// - After mode load, precharge power-down waits the mode set delay.
// - Clock change only in precharge power-down, after two clocks, ODT and CKE low.
// - After clock change, new clocks before exit, DLL reset, ODT off 200 cycles.
`timescale 1ns/1ps
module dpc_ctrl (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// User request port
	input wire logic req_valid,
	input wire logic [1:0] req_kind,
	input wire logic wake,
	input wire logic busy,
	input wire logic banks_idle,
	input wire logic odt_req,
	input wire logic clk_stable,
	input wire logic [12:0] mr_value,
	input wire logic mr_extra_valid,
	input wire logic [12:0] mr_extra,
	input wire logic [1:0] mr_extra_bank,
	// User status
	output logic req_ready,
	output logic low_power,
	output logic in_self_refresh,
	output logic active_pd,
	output logic fchg_window,
	output logic cmd_allowed,
	output logic read_allowed,
	// Memory pins
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [12:0] addr,
	output logic [1:0] ba,
	output logic odt
);
	dpc_pkg::dpc_state_e state;
	dpc_pkg::dpc_state_e next_state;
	logic [7:0] hold_cnt;
	logic [7:0] read_cnt;
	logic [1:0] kind;
	logic was_fchg;
	logic [3:0] next_cmd;
	logic next_cke;
	logic [12:0] next_addr;
	logic [1:0] next_ba;
	logic cke_ok;

	////////////////////////////////////////////////////////////////////
	// Entry checks
	// CKE hold count
	assign cke_ok = (hold_cnt == dpc_pkg::CNT_ZERO);

	always_comb begin
		next_state = state;
		next_cke = cke;
		next_cmd = dpc_pkg::CMD_NOP;
		next_addr = 13'h0000;
		next_ba = 2'h0;
		unique case (state)
			dpc_pkg::ST_RUN: begin
				next_cke = 1'b1;
				// Entry only when idle of bursts
				if (req_valid && !busy && cke_ok && req_kind != 2'h0) begin
					// Self refresh and clock change need all banks idle
					if (req_kind == dpc_pkg::REQ_PDN || banks_idle) begin
						next_state = dpc_pkg::ST_ENTER;
					end
				end
			end
			dpc_pkg::ST_ENTER: begin
				// Legal entry edge: NOP or REFRESH with CKE low
				next_cke = 1'b0;
				if (kind == dpc_pkg::REQ_SREF) begin
					next_cmd = dpc_pkg::CMD_REF;
					next_state = dpc_pkg::ST_SREF;
				end else begin
					next_cmd = dpc_pkg::CMD_NOP;
					next_state = (kind == dpc_pkg::REQ_FCHG) ? dpc_pkg::ST_FCHG
						: dpc_pkg::ST_PDN;
				end
			end
			dpc_pkg::ST_PDN, dpc_pkg::ST_SREF: begin
				next_cke = 1'b0;
				// Exit on user wake after minimum low time
				if (wake && cke_ok) begin
					next_cke = 1'b1;
					next_state = dpc_pkg::ST_EXIT;
				end
			end
			dpc_pkg::ST_FCHG: begin
				next_cke = 1'b0;
				// Exit only with new clocks stable
				if (wake && cke_ok && clk_stable) begin
					next_cke = 1'b1;
					next_state = dpc_pkg::ST_EXIT;
				end
			end
			dpc_pkg::ST_EXIT: begin
				next_cke = 1'b1;
				if (cke_ok) begin
					if (was_fchg) begin
						next_cmd = dpc_pkg::CMD_LM;
						next_addr = mr_value | (13'h0001 << dpc_pkg::MR_DLL_RST_BIT);
						next_state = dpc_pkg::ST_RELOCK;
					end else begin
						next_state = dpc_pkg::ST_RUN;
					end
				end
			end
			dpc_pkg::ST_RELOCK: begin
				next_cke = 1'b1;
				// Extra mode loads, write recovery field from user
				if (mr_extra_valid && hold_cnt[0]) begin
					next_cmd = dpc_pkg::CMD_LM;
					next_addr = mr_extra;
					next_ba = mr_extra_bank;
				end
				if (cke_ok) begin
					next_state = dpc_pkg::ST_RUN;
				end
			end
			default: next_state = dpc_pkg::ST_RUN;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State and counters
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= dpc_pkg::ST_RUN;
			kind <= 2'h0;
			was_fchg <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			if (state == dpc_pkg::ST_RUN && next_state == dpc_pkg::ST_ENTER) begin
				kind <= req_kind;
				was_fchg <= (req_kind == dpc_pkg::REQ_FCHG);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// CKE high time counted from reset release
			hold_cnt <= dpc_pkg::CKE_HOLD;
		end else if (clk_en) begin
			if (next_state != state) begin
				unique case (next_state)
					// Non-read exit interval (self refresh exit only) or CKE hold, whichever longer
					dpc_pkg::ST_EXIT: hold_cnt <= (state == dpc_pkg::ST_SREF &&
						dpc_pkg::NR_HOLD > dpc_pkg::CKE_HOLD) ? dpc_pkg::NR_HOLD
						: dpc_pkg::CKE_HOLD;
					dpc_pkg::ST_FCHG: hold_cnt <= (dpc_pkg::FCHG_HOLD > dpc_pkg::CKE_HOLD)
						? dpc_pkg::FCHG_HOLD : dpc_pkg::CKE_HOLD;
					dpc_pkg::ST_RELOCK: hold_cnt <= dpc_pkg::RELOCK_HOLD;
					dpc_pkg::ST_RUN: hold_cnt <= (state == dpc_pkg::ST_RELOCK)
						? dpc_pkg::CNT_ZERO : hold_cnt;
					default: hold_cnt <= dpc_pkg::CKE_HOLD;
				endcase
			end else if (hold_cnt != dpc_pkg::CNT_ZERO) begin
				hold_cnt <= hold_cnt - dpc_pkg::CNT_ONE;
			end
		end
	end

	// READ lockout after self refresh exit
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			read_cnt <= dpc_pkg::CNT_ZERO;
		end else if (clk_en) begin
			if (state == dpc_pkg::ST_SREF && next_state == dpc_pkg::ST_EXIT) begin
				read_cnt <= dpc_pkg::READ_HOLD;
			end else if (read_cnt != dpc_pkg::CNT_ZERO) begin
				read_cnt <= read_cnt - dpc_pkg::CNT_ONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin and status registers
	// CKE pin, held by the hold counter
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cke <= 1'b0;
		end else if (clk_en) begin
			cke <= next_cke;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cs_n <= 1'b1;
			ras_n <= 1'b1;
			cas_n <= 1'b1;
			we_n <= 1'b1;
			addr <= 13'h0000;
			ba <= 2'h0;
		end else if (clk_en) begin
			{cs_n, ras_n, cas_n, we_n} <= next_cmd;
			addr <= next_addr;
			ba <= next_ba;
		end
	end

	// ODT defined low in self refresh, clock change and relock
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			odt <= 1'b0;
		end else if (clk_en) begin
			unique case (next_state)
				dpc_pkg::ST_SREF, dpc_pkg::ST_FCHG, dpc_pkg::ST_RELOCK: odt <= 1'b0;
				dpc_pkg::ST_ENTER: odt <= (kind == dpc_pkg::REQ_PDN) ? odt_req : 1'b0;
				dpc_pkg::ST_EXIT: odt <= was_fchg ? 1'b0 : odt_req;
				default: odt <= odt_req;
			endcase
		end
	end

	// Requests and user commands only in plain operation
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			req_ready <= 1'b0;
			cmd_allowed <= 1'b0;
		end else if (clk_en) begin
			// Not ready until the CKE high time is met
			req_ready <= (next_state == dpc_pkg::ST_RUN) && (hold_cnt <= dpc_pkg::CNT_ONE)
				&& !(req_valid && next_state != state);
			cmd_allowed <= (next_state == dpc_pkg::ST_RUN);
		end
	end

	// Reads wait out the lockout after self refresh exit
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			read_allowed <= 1'b0;
		end else if (clk_en) begin
			read_allowed <= (next_state == dpc_pkg::ST_RUN) && (read_cnt <= dpc_pkg::CNT_ONE);
		end
	end

	// Low-power flags follow the CKE level and entry kind
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			low_power <= 1'b0;
			in_self_refresh <= 1'b0;
		end else if (clk_en) begin
			low_power <= !next_cke;
			in_self_refresh <= (next_state == dpc_pkg::ST_SREF);
		end
	end

	// Active power-down when a row was open at entry
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			active_pd <= 1'b0;
		end else if (clk_en) begin
			if (state == dpc_pkg::ST_ENTER) begin
				active_pd <= (kind == dpc_pkg::REQ_PDN) && !banks_idle;
			end else if (next_state == dpc_pkg::ST_RUN) begin
				active_pd <= 1'b0;
			end
		end
	end

	// Clock may change after two clocks of CKE low
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fchg_window <= 1'b0;
		end else if (clk_en) begin
			fchg_window <= (next_state == dpc_pkg::ST_FCHG) && (hold_cnt == dpc_pkg::CNT_ONE
				|| (state == dpc_pkg::ST_FCHG && cke_ok));
		end
	end
endmodule

// File: dpc_ctrl_assertions.sv
// Assertions on the CKE power-state controller ports
`timescale 1ns/1ps
module dpc_ctrl_checker (
	// Clock and control
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic busy,
	input wire logic banks_idle,
	// Status
	input wire logic low_power,
	input wire logic in_self_refresh,
	input wire logic fchg_window,
	input wire logic read_allowed,
	// Memory pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic odt
);
	logic [3:0] cmd;
	logic [8:0] sr_cnt;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	// Clocks since self refresh exit
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sr_cnt <= 9'h1ff;
		end else if (in_self_refresh && !cke) begin
			sr_cnt <= 9'h000;
		end else if (clk_en && sr_cnt != 9'h1ff) begin
			sr_cnt <= sr_cnt + 9'h001;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_low_hold: assert property ($fell(cke) |-> !cke [*3])
		else $error("cke low shorter than three clocks");
	a_high_hold: assert property ($rose(cke) |-> cke [*3])
		else $error("cke high shorter than three clocks");
	a_entry_cmd: assert property ($fell(cke) |-> cmd[3] || cmd inside {4'h7, 4'h1})
		else $error("bad command on cke fall");
	a_exit_cmd: assert property ($rose(cke) |-> cmd[3] || cmd == 4'h7)
		else $error("bad command on cke rise");
	a_entry_idle: assert property ($fell(cke) |-> !$past(busy))
		else $error("low power entered while busy");
	a_sref_idle: assert property ($fell(cke) && cmd == 4'h1 |-> $past(banks_idle))
		else $error("self refresh with open rows");
	a_sref_odt: assert property (in_self_refresh |-> !odt)
		else $error("odt high in self refresh");
	a_fchg_quiet: assert property (fchg_window |-> !cke && !odt && !$past(cke, 2))
		else $error("clock change window too early or not quiet");
	a_low_pin: assert property (low_power |-> !cke)
		else $error("low power flag with cke high");
	a_read_lock: assert property (read_allowed |-> sr_cnt >= 9'h0c7)
		else $error("read allowed too soon after self refresh");
endmodule
bind dpc_ctrl dpc_ctrl_checker i_dpc_ctrl_checker (.mclk(mclk), .sys_rst(sys_rst),
	.clk_en(clk_en), .busy(busy), .banks_idle(banks_idle), .low_power(low_power),
	.in_self_refresh(in_self_refresh), .fchg_window(fchg_window), .read_allowed(read_allowed),
	.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt));

// File: dpc_dev_model.sv
// Behavioural DDR2 device power-state model
`timescale 1ns/1ps
module dpc_dev_model (
	// Pins
	input wire logic mclk,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic [12:0] addr,
	input wire logic rows_open,
	// Observed state: 0 run, 1 precharge pd, 2 active pd, 3 self refresh
	output logic [1:0] pstate = 2'h0,
	output logic illegal = 1'b0,
	output logic [12:0] mode_reg = 13'h0000
);
	logic cke_prev = 1'b0;
	logic [3:0] cmd;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	always_ff @(posedge mclk) cke_prev <= cke;
	always_ff @(posedge mclk) begin
		if (cke_prev && !cke) begin
			if (cmd == 4'h1 && !rows_open) pstate <= 2'h3;
			else if (cmd[3] || cmd == 4'h7) pstate <= rows_open ? 2'h2 : 2'h1;
			else illegal <= 1'b1;
		end else if (!cke_prev && cke) begin
			if (cmd[3] || cmd == 4'h7) pstate <= 2'h0;
			else illegal <= 1'b1;
		end
	end
	always_ff @(posedge mclk) if (cke_prev && cke && cmd == 4'h0 && ba == 2'h0) mode_reg <= addr;
endmodule

// File: dpc_ctrl_bench.sv
// Testbench for the CKE power-state controller
`timescale 1ns/1ps
module dpc_ctrl_bench;
	logic mclk = 0, sys_rst = 1, clk_en = 1, req_valid = 0, wake = 0, busy = 0, banks_idle = 1;
	logic odt_req = 1, clk_stable = 1, mr_extra_valid = 1;
	logic [1:0] req_kind = 2'h0, mr_extra_bank = 2'h1, ba, pst;
	logic [12:0] mr_value = 13'h0a53, mr_extra = 13'h00ff, addr, mreg;
	logic req_ready, low_power, in_sr, active_pd, fchg_window, cmd_allowed, read_allowed;
	logic cke, cs_n, ras_n, cas_n, we_n, odt, ill;
	int n_errors = 0, num_checks = 0, cyc = 0, i;
	dpc_ctrl i_dpc_ctrl (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid),
		.req_kind(req_kind), .wake(wake), .busy(busy), .banks_idle(banks_idle), .odt_req(odt_req),
		.clk_stable(clk_stable), .mr_value(mr_value), .mr_extra_valid(mr_extra_valid),
		.mr_extra(mr_extra), .mr_extra_bank(mr_extra_bank), .req_ready(req_ready),
		.low_power(low_power), .in_self_refresh(in_sr), .active_pd(active_pd),
		.fchg_window(fchg_window), .cmd_allowed(cmd_allowed), .read_allowed(read_allowed),
		.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .ba(ba),
		.odt(odt));
	dpc_dev_model i_dpc_dev_model (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .rows_open(!banks_idle), .pstate(pst),
		.illegal(ill), .mode_reg(mreg));
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	task check(string nm, logic seen, logic exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, seen);
		end
	endtask
	task step(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task enter(logic [1:0] k);
		req_kind = k;
		req_valid = 1;
		step(1);
		req_valid = 0;
		step(2);
	endtask
	task leave();
		wake = 1;
		for (i = 0; i < 400 && req_ready !== 1'b1; i++) step(1);
		wake = 0;
		step(1);
	endtask
	task test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		step(16);
		sys_rst = 0;
		step(3);
		enter(dpc_pkg::REQ_PDN);
		check("precharge pd", pst === 2'h1, 1);
		check("odt level", odt, 1);
		check("low power flag", low_power, 1);
		check("precharge flag", active_pd, 0);
		check("ready in pd", req_ready, 0);
		clk_en = 0;
		wake = 1;
		step(5);
		check("frozen cke", cke, 0);
		clk_en = 1;
		leave();
		check("pd exit", pst === 2'h0, 1);
		check("cmd allowed", cmd_allowed, 1);
		check("low power clear", low_power, 0);
		banks_idle = 0;
		enter(dpc_pkg::REQ_PDN);
		check("active pd", pst === 2'h2, 1);
		check("active flag", active_pd, 1);
		leave();
		enter(dpc_pkg::REQ_SREF);
		check("sref rows open", cke, 1);
		banks_idle = 1;
		busy = 1;
		enter(dpc_pkg::REQ_PDN);
		check("busy refused", cke, 1);
		busy = 0;
		enter(2'h0);
		check("kind zero", cke, 1);
		enter(dpc_pkg::REQ_SREF);
		check("sref state", pst === 2'h3, 1);
		check("sref odt", odt, 0);
		check("sref flag", in_sr, 1);
		wake = 1;
		for (i = 0; i < 50 && cke !== 1'b1; i++) step(1);
		for (i = 0; i < 400 && read_allowed !== 1'b1; i++) step(1);
		check("read lockout", i >= 199 && i < 400, 1);
		leave();
		enter(dpc_pkg::REQ_FCHG);
		step(2);
		check("change window", fchg_window, 1);
		check("change pd kind", pst === 2'h1, 1);
		clk_stable = 0;
		wake = 1;
		step(6);
		check("wait stable clock", cke, 0);
		clk_stable = 1;
		for (i = 0; i < 50 && cke !== 1'b1; i++) step(1);
		step(50);
		check("relock odt", odt, 0);
		leave();
		check("dll reset load", mreg[8], 1);
		check("no illegal combo", ill, 0);
		test_done();
	end
endmodule
